/* File: bench/sbc_bus_partner.sv */
// Purpose: another master on the two-wire bus, plus the pull-ups
// Assumes: bench raises go_frame or go_stop to command it
// Notes: scl stands still outside its frames
`timescale 1ns/1ps
module sbc_bus_partner
(
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  input wire logic go_frame,
  input wire logic go_stop,
  output logic scl_in,
  output logic sda_in
);
  logic p_scl = 1'b1;
  logic p_sda = 1'b1;

  // wired-and with pull-ups: low if either side pulls
  assign scl_in = scl_oe_n & p_scl;
  assign sda_in = sda_oe_n & p_sda;

  // start, address byte all ones, nine clocks of 94 ns, then scl held low
  always @(posedge go_frame)
  begin
    p_sda = 1'b0;
    #62.5 p_scl = 1'b0;
    #31 p_sda = 1'b1;
    repeat (9)
    begin
      #31.5 p_scl = 1'b1;
      #62.5 p_scl = 1'b0;
    end
  end

  // stop: sda low under low scl, scl up, then sda up
  always @(posedge go_stop)
  begin
    p_sda = 1'b0;
    #62.5 p_scl = 1'b1;
    #62.5 p_sda = 1'b1;
  end
endmodule : sbc_bus_partner

/* File: bench/sbc_control_sva.sv */
// Purpose: port-level checks of the serial bus control block
// Assumes: control bits are mirrored from completed APB writes
// Notes: hardware clearing of master select is not mirrored
`timescale 1ns/1ps
module sbc_control_chk
  import sbc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  input wire logic irq
);
  // ----------------------------------------------------------------
  // control mirror
  // ----------------------------------------------------------------
  logic [7:0] ctl_sh;
  logic en_sh;
  logic ien_sh;
  logic ms_sh;
  logic mapped;
  assign en_sh = ctl_sh[CTRL_EN];
  assign ien_sh = ctl_sh[CTRL_IEN];
  assign ms_sh = ctl_sh[CTRL_MS];
  assign mapped = paddr inside {ADDR_OWN, ADDR_CTRL, ADDR_STAT, ADDR_DATA};

  // mirror lands on the same edge as the real write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctl_sh <= 8'h00;
    else if (psel && penable && pready && pwrite && paddr == ADDR_CTRL)
      ctl_sh <= pwdata[7:0];
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // own start: sda falls while scl is still released
  sequence s_start_edge;
    ms_sh && $fell(sda_oe_n) && scl_oe_n;
  endsequence

  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_unmapped: assert property (pready |-> pslverr == !mapped)
    else $error("slave error does not match address");
  a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_ctrl_rsv_zero: assert property (pready && !pwrite && paddr == ADDR_CTRL |->
    prdata[2:0] == 3'h0 && prdata[31:8] == 24'h0)
    else $error("control read shows write-only or reserved bits");
  a_irq_masked: assert property (!ien_sh && !$past(ien_sh) |-> !irq)
    else $error("interrupt raised while masked");
  a_lines_disabled: assert property (!en_sh && !$past(en_sh) && !$past(en_sh, 2)
    |-> sda_oe_n && scl_oe_n)
    else $error("bus driven while disabled");
  a_start_order: assert property (s_start_edge |=> scl_oe_n [*8])
    else $error("scl pulled too soon after start");
  a_stop_order: assert property ($rose(sda_oe_n) && en_sh && !ms_sh
    |-> $past(scl_oe_n, 8))
    else $error("sda released before scl on stop");
endmodule : sbc_control_chk

/* File: bench/sbc_control_top_test.sv */
// Purpose: register-level test of the serial bus control block
// Assumes: APB answers after one access cycle, half scl period 500 cycles
// Notes: the partner model plays a rival master
`timescale 1ns/1ps
module sbc_control_top_test
  import sbc_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic pready, pslverr, err, irq, go_frame = 1'b0, go_stop = 1'b0;
  logic scl_in, scl_oe_n, sda_in, sda_oe_n;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;

  always #5 pclk = ~pclk;

  sbc_control_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl_in), .scl_out(), .scl_oe_n(scl_oe_n), .sda_in(sda_in),
    .sda_out(), .sda_oe_n(sda_oe_n), .irq(irq));
  sbc_bus_partner far_u (.scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .go_frame(go_frame),
    .go_stop(go_stop), .scl_in(scl_in), .sda_in(sda_in));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one transfer; request held until pready is sampled high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("read data", q & m, e);
  endtask : rd

  task end_sim;
    if (n_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  // hang guard, well above the eleven and a half thousand cycles needed
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADDR_CTRL, 32'hffffffff, 32'h00);
    rd(ADDR_STAT, 32'hffffffff, 32'h81);
    rd(ADDR_CTRL_SECOND, 32'hffffffff, 32'h0);
    chk("slave error", err, 1'b1);
    // master select without enable must stay quiet
    apb(1'b1, ADDR_CTRL, 32'h27);
    repeat (20) @(posedge pclk);
    chk("sda drive", sda_oe_n, 1'b1);
    rd(ADDR_CTRL, 32'hffffffff, 32'h20);
    // own start on an idle bus, scl then held low
    apb(1'b1, ADDR_CTRL, 32'h80);
    apb(1'b1, ADDR_CTRL, 32'ha0);
    for (int n = 0; n < 20 && sda_oe_n !== 1'b0; n++)
      @(posedge pclk);
    chk("sda drive", sda_oe_n, 1'b0);
    repeat (400) @(posedge pclk);
    chk("scl drive", scl_oe_n, 1'b1);
    repeat (150) @(posedge pclk);
    chk("scl drive", scl_oe_n, 1'b0);
    // address byte goes out as transmitter; ack bit left at zero must not act
    apb(1'b1, ADDR_CTRL, 32'hb0);
    apb(1'b1, ADDR_DATA, 32'h5a);
    repeat (100) @(posedge pclk);
    chk("sda drive", sda_oe_n, 1'b0);
    rd(ADDR_STAT, 32'h82, 32'h00);
    repeat (9200) @(posedge pclk);
    rd(ADDR_STAT, 32'h83, 32'h83);
    apb(1'b1, ADDR_CTRL, 32'h80);
    repeat (1200) @(posedge pclk);
    chk("lines released", {scl_oe_n, sda_oe_n}, 2'b11);
    rd(ADDR_STAT, 32'h30, 32'h00);
    // repeated start without owning the bus
    apb(1'b1, ADDR_CTRL, 32'hc4);
    repeat (5) @(posedge pclk);
    chk("irq", irq, 1'b1);
    rd(ADDR_STAT, 32'h12, 32'h12);
    rd(ADDR_CTRL, 32'hff, 32'hc0);
    apb(1'b1, ADDR_CTRL, 32'h80);
    repeat (3) @(posedge pclk);
    chk("irq", irq, 1'b0);
    rd(ADDR_STAT, 32'h02, 32'h02);
    apb(1'b1, ADDR_CTRL, 32'hc0);
    repeat (3) @(posedge pclk);
    chk("irq", irq, 1'b1);
    apb(1'b1, ADDR_STAT, 32'h00);
    repeat (3) @(posedge pclk);
    chk("irq", irq, 1'b0);
    // rival frame calls our address for a read; a start attempt then loses
    apb(1'b1, ADDR_OWN, 32'hfe);
    go_frame <= 1'b1;
    repeat (200) @(posedge pclk);
    rd(ADDR_STAT, 32'h66, 32'h66);
    apb(1'b1, ADDR_CTRL, q[STAT_SRW] ? 32'h90 : 32'h80);
    rd(ADDR_STAT, 32'h40, 32'h00);
    apb(1'b1, ADDR_CTRL, 32'ha0);
    repeat (10) @(posedge pclk);
    rd(ADDR_CTRL, 32'hff, 32'h80);
    rd(ADDR_STAT, 32'h12, 32'h12);
    chk("sda drive", sda_oe_n, 1'b1);
    // disabling mid-frame drops bus busy
    apb(1'b1, ADDR_STAT, 32'h00);
    apb(1'b1, ADDR_CTRL, 32'h00);
    repeat (5) @(posedge pclk);
    rd(ADDR_STAT, 32'h20, 32'h00);
    go_stop <= 1'b1;
    repeat (50) @(posedge pclk);
    end_sim();
  end
endmodule : sbc_control_top_test

bind sbc_control_top sbc_control_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .irq(irq));

/* File: hdl/sbc_bus_events.sv */
// Purpose: finds clock edges and start/stop conditions on the synchronised bus
// Assumes: scl and sda already passed two flops
// Notes: every output is a flop; pulses last one cycle
`timescale 1ns/1ps
module sbc_bus_events
  import sbc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl,
  input wire logic sda,
  output logic scl_lvl,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_det,
  output logic stop_det
);

  typedef struct packed {
    logic scl_q;
    logic sda_q;
    logic rise;
    logic fall;
    logic start;
    logic stop;
  } sbc_ev_t;

  sbc_ev_t s;
  sbc_ev_t next_s;

  // ----------------------------------------------------------------
  // edge and condition detection
  // ----------------------------------------------------------------
  // a data edge only counts as start or stop while the clock stays high
  always_comb
  begin
    next_s = s;
    next_s.scl_q = scl;
    next_s.sda_q = sda;
    next_s.rise = scl & ~s.scl_q;
    next_s.fall = ~scl & s.scl_q;
    next_s.start = scl & s.scl_q & s.sda_q & ~sda;
    next_s.stop = scl & s.scl_q & ~s.sda_q & sda;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '{scl_q: 1'b1, sda_q: 1'b1, rise: 1'b0, fall: 1'b0, start: 1'b0, stop: 1'b0};
    else
      s <= next_s;
  end

  assign scl_lvl = s.scl_q;
  assign scl_rise = s.rise;
  assign scl_fall = s.fall;
  assign start_det = s.start;
  assign stop_det = s.stop;

endmodule : sbc_bus_events

/* File: hdl/sbc_control_top.sv */
// Purpose: control register logic and byte engine of a two-wire serial bus port
// Assumes: APB slave, zero wait after the setup cycle, open-drain pins
// Notes: module enable doubles as soft reset of the engine
//
// Summary of operation
// - Enable bit 7 soft-resets engine and clears bus busy; other registers stay.
// - Enabled mid-byte, slave waits for next start.
// - Enabled mid-byte, master ignores busy bus.
// - Other control bits act only when enabled; interrupt enable still gates irq while disabled.
// - Interrupt enable masks, never clears pending flag.
// - Interrupt output equals enable and pending flag.
// - Arbitration loss clears master select, no stop.
// - Master select one-to-zero drives stop, slave role.
// - Master select zero-to-one drives start, master role.
// - Direction bit: zero receive, one transmit.
// - Receiver acks low when ack bit zero.
// - Ack bit ignored while transmitting.
// - Repeated start request generates start, reads zero.
// - Repeated start without bus ownership loses arbitration.
// - Pending flag: byte done, address match, lost.
// - Slave read/write status: zero write, one read.
// - Start attempt on busy bus loses arbitration.
// - Any control write clears addressed-as-slave flag.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module sbc_control_top
  import sbc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic irq
);

  typedef struct packed {
    logic ctrl_en;
    logic ctrl_ien;
    logic ctrl_ms;
    logic ctrl_dir;
    logic ctrl_ack;
    logic [6:0] own_addr;
    logic [7:0] tx_data;
    logic [7:0] rx_data;
    logic st_icf;
    logic st_aas;
    logic st_bb;
    logic st_al;
    logic st_srw;
    logic st_iif;
    logic st_rxak;
    sbc_mstate_t mst;
    logic [9:0] tmr;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic xfer;
    logic addr_phase;
    logic addr_hit;
    logic slave_act;
    logic skip_fall;
    logic drv_scl_low;
    logic drv_sda_low;
    logic [31:0] rdata;
    logic rdy;
    logic err;
    logic irq_q;
  } sbc_state_t;

  sbc_state_t s;
  sbc_state_t next_s;
  logic [1:0] pins_s;
  logic scl_lvl;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic sda_lvl;
  logic wr_acc;
  logic rd_acc;
  logic owner;
  logic is_tx;
  logic act_bits;
  logic lose;
  logic [7:0] new_byte;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == ADDR_OWN) || (a == ADDR_CTRL) || (a == ADDR_STAT) || (a == ADDR_DATA);
  endfunction : is_mapped

  // data line level for the bit about to go out; the ack slot at LAST_BIT is handled here too
  function automatic logic sda_low(input logic [3:0] cnt, input logic [7:0] sh,
                                   input logic tx, input logic ack_low);
    sda_low = (cnt == LAST_BIT) ? (~tx & ack_low) : (tx & ~sh[7]);
  endfunction : sda_low

  // ----------------------------------------------------------------
  // pin synchronisation and bus events
  // ----------------------------------------------------------------
  sbc_sync2 u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({scl_in, sda_in}),
    .dout(pins_s)
  );

  sbc_bus_events u_events (
    .pclk(pclk),
    .presetn(presetn),
    .scl(pins_s[1]),
    .sda(pins_s[0]),
    .scl_lvl(scl_lvl),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det)
  );

  assign sda_lvl = pins_s[0];
  assign wr_acc = psel & penable & pwrite & s.rdy;
  assign rd_acc = psel & penable & ~pwrite & s.rdy;
  assign owner = (s.mst != M_IDLE);
  // slave address byte is always received; otherwise the direction bit rules
  assign is_tx = owner ? s.ctrl_dir : (~s.addr_phase & s.ctrl_dir);
  assign act_bits = owner ? s.xfer : s.slave_act;
  assign new_byte = {s.shift[6:0], sda_lvl};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    lose = 1'b0;
    // apb: answer is prepared in the setup cycle, ready for one access cycle
    next_s.rdy = psel & ~penable;
    next_s.err = psel & ~penable & ~is_mapped(paddr);
    next_s.rdata = 32'h0;
    if (psel && !penable)
    begin
      case (paddr)
        ADDR_OWN: next_s.rdata = {24'h0, s.own_addr, 1'b0};
        // repeated start and reserved bits always read zero
        ADDR_CTRL: next_s.rdata = {24'h0, s.ctrl_en, s.ctrl_ien, s.ctrl_ms, s.ctrl_dir,
                                   s.ctrl_ack, 3'h0};
        ADDR_STAT: next_s.rdata = {24'h0, s.st_icf, s.st_aas, s.st_bb, s.st_al, 1'b0,
                                   s.st_srw, s.st_iif, s.st_rxak};
        ADDR_DATA: next_s.rdata = {24'h0, s.rx_data};
        default: next_s.rdata = 32'h0;
      endcase
    end
    if (s.tmr != 10'h0)
      next_s.tmr = s.tmr - 10'h1;

    // register writes
    if (wr_acc && paddr == ADDR_OWN)
      next_s.own_addr = pwdata[7:1];
    if (wr_acc && paddr == ADDR_STAT)
    begin
      if (!pwdata[STAT_AL])
        next_s.st_al = 1'b0;
      if (!pwdata[STAT_IF])
        next_s.st_iif = 1'b0;
    end
    if (wr_acc && paddr == ADDR_CTRL)
    begin
      next_s.ctrl_en = pwdata[CTRL_EN];
      next_s.ctrl_ien = pwdata[CTRL_IEN];
      next_s.ctrl_ms = pwdata[CTRL_MS];
      next_s.ctrl_dir = pwdata[CTRL_DIR];
      next_s.ctrl_ack = pwdata[CTRL_ACK];
      next_s.st_aas = 1'b0;
      // bus actions only once the module is enabled
      if (pwdata[CTRL_EN] && s.ctrl_en)
      begin
        if (!s.ctrl_ms && pwdata[CTRL_MS])
        begin
          // busy flag is cleared while disabled, so a late enable may collide
          if (s.st_bb || owner)
            lose = 1'b1;
          else
          begin
            next_s.mst = M_START;
            next_s.tmr = SCL_HALF_CYC;
          end
        end
        else if (s.ctrl_ms && !pwdata[CTRL_MS] && owner)
        begin
          next_s.mst = M_STOP1;
          next_s.tmr = SCL_HALF_CYC;
        end
        else if (pwdata[CTRL_RS])
        begin
          if (s.mst == M_OWN)
          begin
            next_s.mst = M_RS1;
            next_s.tmr = SCL_HALF_CYC;
            next_s.drv_sda_low = 1'b0;
          end
          else
            lose = 1'b1;
        end
      end
    end
    if (wr_acc && paddr == ADDR_DATA)
    begin
      next_s.tx_data = pwdata[7:0];
      if (s.ctrl_en && (s.mst == M_OWN || (!owner && s.slave_act && s.bit_cnt == 4'h0)))
      begin
        next_s.shift = pwdata[7:0];
        next_s.st_icf = 1'b0;
        next_s.drv_sda_low = is_tx & ~pwdata[7];
        if (owner)
        begin
          next_s.xfer = 1'b1;
          next_s.bit_cnt = 4'h0;
          next_s.mst = M_LOW;
          next_s.tmr = SCL_HALF_CYC;
        end
      end
    end
    // master receive: reading the data starts the next byte
    if (rd_acc && paddr == ADDR_DATA && s.ctrl_en && s.mst == M_OWN && !s.ctrl_dir)
    begin
      next_s.xfer = 1'b1;
      next_s.bit_cnt = 4'h0;
      next_s.st_icf = 1'b0;
      next_s.drv_sda_low = 1'b0;
      next_s.mst = M_LOW;
      next_s.tmr = SCL_HALF_CYC;
    end

    // bit engine on observed clock edges
    if (start_det)
    begin
      next_s.st_bb = 1'b1;
      next_s.slave_act = ~owner;
      next_s.addr_phase = ~owner;
      next_s.addr_hit = 1'b0;
      next_s.bit_cnt = 4'h0;
      next_s.skip_fall = 1'b1;
    end
    if (stop_det)
    begin
      next_s.st_bb = 1'b0;
      next_s.slave_act = 1'b0;
      if (owner && s.mst != M_STOP2)
        lose = 1'b1;
    end
    if (scl_rise && act_bits)
    begin
      if (s.bit_cnt != LAST_BIT)
      begin
        next_s.shift = new_byte;
        // we released a one but the line reads low: another master won
        if (owner && is_tx && s.shift[7] && !sda_lvl)
          lose = 1'b1;
        if (s.addr_phase && s.bit_cnt == 4'h7 && new_byte[7:1] == s.own_addr)
        begin
          next_s.addr_hit = 1'b1;
          next_s.st_aas = 1'b1;
          next_s.st_srw = new_byte[0];
          next_s.st_iif = 1'b1;
        end
      end
      else if (is_tx)
        next_s.st_rxak = sda_lvl;
    end
    if (scl_fall)
    begin
      if (s.skip_fall)
        next_s.skip_fall = 1'b0;
      else if (act_bits)
      begin
        if (s.bit_cnt == LAST_BIT)
        begin
          next_s.bit_cnt = 4'h0;
          next_s.st_icf = 1'b1;
          next_s.st_iif = 1'b1;
          next_s.rx_data = s.shift;
          next_s.xfer = 1'b0;
          next_s.addr_phase = 1'b0;
          if (s.addr_phase && !s.addr_hit)
            next_s.slave_act = 1'b0;
          if (!owner && s.ctrl_dir)
            next_s.shift = s.tx_data;
          next_s.drv_sda_low = ~owner & s.ctrl_dir & ~s.tx_data[7];
        end
        else
        begin
          next_s.bit_cnt = s.bit_cnt + 4'h1;
          // address ack depends on the match; data ack on the ack bit
          next_s.drv_sda_low = sda_low(s.bit_cnt + 4'h1, s.shift, is_tx,
                                       s.addr_phase ? s.addr_hit : ~s.ctrl_ack);
        end
      end
    end

    // master sequencer
    case (s.mst)
      M_IDLE: ;
      M_START:
      begin
        next_s.drv_sda_low = 1'b1;
        if (s.tmr == 10'h0)
        begin
          next_s.drv_scl_low = 1'b1;
          next_s.mst = M_OWN;
        end
      end
      M_OWN: next_s.drv_scl_low = 1'b1;
      M_LOW:
      begin
        if (!s.xfer)
          next_s.mst = M_OWN;
        else if (s.tmr == 10'h0)
        begin
          next_s.drv_scl_low = 1'b0;
          next_s.mst = M_HIGH;
          next_s.tmr = SCL_HALF_CYC;
        end
      end
      M_HIGH:
      begin
        // a slave may stretch the clock, so wait for the line itself
        if (s.tmr == 10'h0 && scl_lvl)
        begin
          next_s.drv_scl_low = 1'b1;
          next_s.mst = M_LOW;
          next_s.tmr = SCL_HALF_CYC;
        end
      end
      M_STOP1:
      begin
        next_s.drv_sda_low = 1'b1;
        if (s.tmr == 10'h0)
        begin
          next_s.drv_scl_low = 1'b0;
          next_s.mst = M_STOP2;
          next_s.tmr = SCL_HALF_CYC;
        end
      end
      M_STOP2:
      begin
        if (s.tmr == 10'h0)
        begin
          next_s.drv_sda_low = 1'b0;
          next_s.mst = M_IDLE;
        end
      end
      M_RS1:
      begin
        if (s.tmr == 10'h0)
        begin
          next_s.drv_scl_low = 1'b0;
          next_s.mst = M_RS2;
          next_s.tmr = SCL_HALF_CYC;
        end
      end
      M_RS2:
      begin
        if (s.tmr == 10'h0 && scl_lvl)
        begin
          next_s.drv_sda_low = 1'b1;
          next_s.mst = M_RS3;
          next_s.tmr = SCL_HALF_CYC;
        end
      end
      M_RS3:
      begin
        if (s.tmr == 10'h0)
        begin
          next_s.drv_scl_low = 1'b1;
          next_s.mst = M_OWN;
        end
      end
      default: next_s.mst = M_IDLE;
    endcase

    // lost arbitration: drop to slave silently, no stop on the bus
    if (lose)
    begin
      next_s.mst = M_IDLE;
      next_s.ctrl_ms = 1'b0;
      next_s.drv_scl_low = 1'b0;
      next_s.drv_sda_low = 1'b0;
      next_s.xfer = 1'b0;
      next_s.st_al = 1'b1;
      next_s.st_iif = 1'b1;
    end

    // disabled: engine held in reset, registers still reachable
    if (!s.ctrl_en)
    begin
      next_s.mst = M_IDLE;
      next_s.drv_scl_low = 1'b0;
      next_s.drv_sda_low = 1'b0;
      next_s.xfer = 1'b0;
      next_s.slave_act = 1'b0;
      next_s.addr_phase = 1'b0;
      next_s.bit_cnt = 4'h0;
      next_s.st_bb = 1'b0;
    end
    next_s.irq_q = next_s.ctrl_ien & next_s.st_iif;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
      s.mst <= M_IDLE;
      s.own_addr <= OWN_RESET[7:1];
      s.tx_data <= DATA_RESET;
      s.rx_data <= DATA_RESET;
      s.st_icf <= STAT_RESET[STAT_ICF];
      s.st_rxak <= STAT_RESET[STAT_RXAK];
      s.ctrl_en <= CTRL_RESET[CTRL_EN];
    end
    else
      s <= next_s;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // open drain: data out is held low, enable low means pulling the line
  assign prdata = s.rdata;
  assign pready = s.rdy;
  assign pslverr = s.err;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n = ~s.drv_scl_low;
  assign sda_oe_n = ~s.drv_sda_low;
  assign irq = s.irq_q;

endmodule : sbc_control_top

/* File: hdl/sbc_pkg.sv */
// Purpose: shared constants and types of the serial bus control block
// Assumes: pclk at 100 MHz, APB byte addresses on 12 bits
// Notes: one channel is built; the second channel's control offset is kept but not decoded
package sbc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_OWN = 12'h300;
  localparam logic [11:0] ADDR_CTRL = 12'h308;
  localparam logic [11:0] ADDR_CTRL_SECOND = 12'h388;
  localparam logic [11:0] ADDR_STAT = 12'h30c;
  localparam logic [11:0] ADDR_DATA = 12'h310;

  // control field positions
  localparam int CTRL_EN = 7;
  localparam int CTRL_IEN = 6;
  localparam int CTRL_MS = 5;
  localparam int CTRL_DIR = 4;
  localparam int CTRL_ACK = 3;
  localparam int CTRL_RS = 2;

  // status field positions
  localparam int STAT_ICF = 7;
  localparam int STAT_AAS = 6;
  localparam int STAT_BB = 5;
  localparam int STAT_AL = 4;
  localparam int STAT_SRW = 2;
  localparam int STAT_IF = 1;
  localparam int STAT_RXAK = 0;

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STAT_RESET = 8'h81;
  localparam logic [7:0] OWN_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_HALF_NS = 5000;
  localparam int SCL_HALF_INT = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] SCL_HALF_CYC = 10'(SCL_HALF_INT < 1 ? 1 : SCL_HALF_INT);
  localparam logic [3:0] LAST_BIT = 4'h8;

  // master sequencer states
  typedef enum logic [3:0] {
    M_IDLE, M_START, M_OWN, M_LOW, M_HIGH, M_STOP1, M_STOP2, M_RS1, M_RS2, M_RS3
  } sbc_mstate_t;

endpackage : sbc_pkg

/* File: hdl/sbc_sync2.sv */
// Purpose: two-flop synchroniser for the clock and data pins
// Assumes: inputs are asynchronous to pclk
// Notes: the first stage feeds only the second stage
`timescale 1ns/1ps
module sbc_sync2
  import sbc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] din,
  output logic [1:0] dout
);

  typedef struct packed {
    logic [1:0] ff1;
    logic [1:0] ff2;
  } sbc_sync_t;

  sbc_sync_t s;
  sbc_sync_t next_s;

  // ----------------------------------------------------------------
  // stages
  // ----------------------------------------------------------------
  // idle bus level is high, so reset to ones to avoid a false start
  always_comb
  begin
    next_s = s;
    next_s.ff1 = din;
    next_s.ff2 = s.ff1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '{ff1: 2'h3, ff2: 2'h3};
    else
      s <= next_s;
  end

  assign dout = s.ff2;

endmodule : sbc_sync2
